// file: dxsc_top.sv
// Excitation sweep control: clock source, divide-by-4, sweep sequencer, NCO.
// Assumes a host-side command decoder drives the plain control ports.
// Contract
// - DDS clock is the master clock divided by four.
// - Output frequency is programmed with 27-bit resolution.
// - DDS clock source is external, RC oscillator or PLL.
// - PLL source multiplies the reference by 520, reference near 32 kHz.
// - Four amplitude ranges: 2 V, 1 V, 0.5 V, 0.2 V.
// - Either steady single frequency or stepped sweep.
// - Excitation begins only after the start command.
// - Programmed frequency is limited to 50 kHz.
// - Each measurement yields a real and an imaginary word.
// - Path is oscillator, modulator, sine table, converter.
// - 27-bit accumulator adds the frequency step each DDS clock cycle.
// - Upper 12 phase bits address the sine table.
`timescale 1ns/1ps
module dxsc_top #(
  parameter int FREQ_W = dxsc_pkg::FREQ_W,
  parameter int PTS_W = dxsc_pkg::PTS_W,
  parameter int SETTLE = dxsc_pkg::SETTLE_CYC
) (
  input wire logic mclk_in,
  input wire logic rst_in,
  input wire logic [1:0] clk_src_in,
  input wire logic rc_tick_in,
  input wire logic pll_tick_in,
  input wire logic [1:0] range_in,
  input wire logic sweep_mode_in,
  input wire logic [FREQ_W-1:0] start_freq_in,
  input wire logic [FREQ_W-1:0] delta_freq_in,
  input wire logic [PTS_W-1:0] num_points_in,
  input wire logic start_in,
  input wire logic stop_in,
  input wire logic meas_done_in,
  input wire logic [15:0] meas_real_in,
  input wire logic [15:0] meas_imag_in,
  output logic [9:0] excitation_output,
  output logic [1:0] range_out,
  output logic [FREQ_W-1:0] freq_out,
  output logic [PTS_W-1:0] point_out,
  output logic dds_ce_out,
  output logic busy_out,
  output logic meas_req_out,
  output logic result_valid_out,
  output logic [15:0] result_real_out,
  output logic [15:0] result_imag_out,
  output logic sweep_done_out,
  output logic pll_mult_out
);
  typedef struct packed {
    dxsc_pkg::dxsc_state_t state;
    logic [1:0] div;
    logic [1:0] src;
    logic [1:0] range;
    logic [FREQ_W-1:0] freq;
    logic [FREQ_W-1:0] delta;
    logic [PTS_W-1:0] pts;
    logic [PTS_W-1:0] point;
    logic [7:0] settle;
    logic meas_req;
    logic res_valid;
    logic [15:0] res_real;
    logic [15:0] res_imag;
    logic done;
    logic rc_s1;
    logic rc_s2;
    logic rc_s3;
    logic pll_s1;
    logic pll_s2;
    logic pll_s3;
  } dxsc_top_t;
  dxsc_top_t r;
  dxsc_top_t next_r;
  logic src_tick;
  logic ce;
  logic run;

  function automatic logic [FREQ_W-1:0] dxsc_clamp(input logic [FREQ_W-1:0] f);
    dxsc_clamp = (f > dxsc_pkg::MAX_STEP) ? dxsc_pkg::MAX_STEP : f;
  endfunction

  // Source ticks come from other oscillators: synchronise, then edge detect
  always_comb begin
    unique case (r.src)
      dxsc_pkg::SRC_RC: src_tick = r.rc_s2 & ~r.rc_s3;
      dxsc_pkg::SRC_PLL: src_tick = r.pll_s2 & ~r.pll_s3;
      default: src_tick = 1'b1;
    endcase
  end

  assign ce = src_tick && (r.div == dxsc_pkg::DIV_LAST);
  assign run = (r.state != dxsc_pkg::DXSC_IDLE);

  always_comb begin
    next_r = r;
    next_r.rc_s1 = rc_tick_in;
    next_r.rc_s2 = r.rc_s1;
    next_r.rc_s3 = r.rc_s2;
    next_r.pll_s1 = pll_tick_in;
    next_r.pll_s2 = r.pll_s1;
    next_r.pll_s3 = r.pll_s2;
    next_r.meas_req = 1'b0;
    next_r.res_valid = 1'b0;
    next_r.done = 1'b0;
    if (src_tick) begin
      next_r.div = (r.div == dxsc_pkg::DIV_LAST) ? 2'h0 : r.div + 2'h1;
    end
    unique case (r.state)
      dxsc_pkg::DXSC_IDLE: begin
        next_r.range = range_in;
        next_r.src = clk_src_in;
        if (start_in) begin
          next_r.freq = dxsc_clamp(start_freq_in);
          next_r.delta = delta_freq_in;
          next_r.pts = num_points_in;
          next_r.point = '0;
          next_r.settle = 8'(SETTLE);
          next_r.state = sweep_mode_in ? dxsc_pkg::DXSC_SWEEP
                                       : dxsc_pkg::DXSC_FIXED;
        end
      end
      dxsc_pkg::DXSC_FIXED: begin
        if (stop_in) begin
          next_r.state = dxsc_pkg::DXSC_IDLE;
        end
      end
      dxsc_pkg::DXSC_SWEEP: begin
        if (stop_in) begin
          next_r.state = dxsc_pkg::DXSC_IDLE;
        end else if (r.settle != 8'h00) begin
          next_r.settle = r.settle - 8'h01;
        end else begin
          next_r.meas_req = 1'b1;
          next_r.state = dxsc_pkg::DXSC_MEAS;
        end
      end
      dxsc_pkg::DXSC_MEAS: begin
        if (stop_in) begin
          next_r.state = dxsc_pkg::DXSC_IDLE;
        end else if (meas_done_in) begin
          next_r.res_valid = 1'b1;
          next_r.res_real = meas_real_in;
          next_r.res_imag = meas_imag_in;
          if (r.point >= r.pts) begin
            next_r.done = 1'b1;
            next_r.state = dxsc_pkg::DXSC_IDLE;
          end else begin
            next_r.point = r.point + PTS_W'(1);
            next_r.freq = dxsc_clamp(FREQ_W'(r.freq + r.delta));
            next_r.settle = 8'(SETTLE);
            next_r.state = dxsc_pkg::DXSC_SWEEP;
          end
        end
      end
      default: next_r.state = dxsc_pkg::DXSC_IDLE;
    endcase
  end

  always_ff @(posedge mclk_in) begin
    if (rst_in) begin
      r <= '0;
      r.state <= dxsc_pkg::DXSC_IDLE;
      r.range <= dxsc_pkg::RANGE_2V;
      r.src <= dxsc_pkg::SRC_EXT;
      r.res_real <= dxsc_pkg::RESULT_RST;
      r.res_imag <= dxsc_pkg::RESULT_RST;
    end else begin
      r <= next_r;
    end
  end

  dxsc_nco u_nco (
    .mclk_in(mclk_in),
    .rst_in(rst_in),
    .ce_in(ce),
    .run_in(run),
    .step_in(r.freq),
    .sine_out(excitation_output)
  );

  assign range_out = r.range;
  assign freq_out = r.freq;
  assign point_out = r.point;
  assign dds_ce_out = ce;
  assign busy_out = run;
  assign meas_req_out = r.meas_req;
  assign result_valid_out = r.res_valid;
  assign result_real_out = r.res_real;
  assign result_imag_out = r.res_imag;
  assign sweep_done_out = r.done;
  assign pll_mult_out = (r.src == dxsc_pkg::SRC_PLL);

  property p_div4;
    @(posedge mclk_in) disable iff (rst_in)
    (r.src == dxsc_pkg::SRC_EXT) && ce |=> !ce [*3] ##1 (ce || r.src != dxsc_pkg::SRC_EXT);
  endproperty
  a_div4: assert property (p_div4) else $error("ce not every fourth cycle");
  property p_start;
    @(posedge mclk_in) disable iff (rst_in)
    r.state == dxsc_pkg::DXSC_IDLE && !start_in |=> r.state == dxsc_pkg::DXSC_IDLE;
  endproperty
  a_start: assert property (p_start) else $error("left idle without start");
  property p_max;
    @(posedge mclk_in) disable iff (rst_in) r.freq <= dxsc_pkg::MAX_STEP;
  endproperty
  a_max: assert property (p_max) else $error("frequency above limit");
  property p_mode;
    @(posedge mclk_in) disable iff (rst_in)
    r.state == dxsc_pkg::DXSC_IDLE && start_in && !sweep_mode_in
    |=> r.state == dxsc_pkg::DXSC_FIXED;
  endproperty
  a_mode: assert property (p_mode) else $error("fixed mode not entered");
  property p_step;
    @(posedge mclk_in) disable iff (rst_in)
    r.state == dxsc_pkg::DXSC_MEAS && meas_done_in && !stop_in && r.point < r.pts
    |=> r.freq == dxsc_clamp(FREQ_W'($past(r.freq) + $past(r.delta)));
  endproperty
  a_step: assert property (p_step) else $error("sweep did not step");
  property p_result;
    @(posedge mclk_in) disable iff (rst_in)
    r.state == dxsc_pkg::DXSC_MEAS && meas_done_in && !stop_in
    |=> result_valid_out && result_real_out == $past(meas_real_in)
        && result_imag_out == $past(meas_imag_in);
  endproperty
  a_result: assert property (p_result) else $error("result words not captured");
  property p_range;
    @(posedge mclk_in) disable iff (rst_in)
    r.state == dxsc_pkg::DXSC_IDLE |=> range_out == $past(range_in);
  endproperty
  a_range: assert property (p_range) else $error("range not taken");
  property p_src;
    @(posedge mclk_in) disable iff (rst_in)
    r.src == dxsc_pkg::SRC_RC && !(r.rc_s2 && !r.rc_s3) |-> !ce;
  endproperty
  a_src: assert property (p_src) else $error("ce without rc tick");
  property p_load;
    @(posedge mclk_in) disable iff (rst_in)
    r.state == dxsc_pkg::DXSC_IDLE && start_in |=> r.delta == $past(delta_freq_in);
  endproperty
  a_load: assert property (p_load) else $error("sweep parameters not loaded");
  property p_busy;
    @(posedge mclk_in) disable iff (rst_in)
    r.state == dxsc_pkg::DXSC_IDLE && start_in |=> busy_out;
  endproperty
  a_busy: assert property (p_busy) else $error("start did not raise busy");
  property p_refuse;
    @(posedge mclk_in) disable iff (rst_in)
    start_in && (r.state == dxsc_pkg::DXSC_SWEEP || r.state == dxsc_pkg::DXSC_FIXED)
    |=> $stable(r.freq);
  endproperty
  a_refuse: assert property (p_refuse) else $error("start taken while busy");
  property p_settle;
    @(posedge mclk_in) disable iff (rst_in)
    r.state == dxsc_pkg::DXSC_SWEEP && r.settle != 8'h00 |=> !meas_req_out;
  endproperty
  a_settle: assert property (p_settle) else $error("request before settling");
  property p_stop;
    @(posedge mclk_in) disable iff (rst_in)
    stop_in && r.state != dxsc_pkg::DXSC_IDLE |=> r.state == dxsc_pkg::DXSC_IDLE;
  endproperty
  a_stop: assert property (p_stop) else $error("stop did not return to idle");
  property p_done;
    @(posedge mclk_in) disable iff (rst_in)
    sweep_done_out |-> result_valid_out && !busy_out;
  endproperty
  a_done: assert property (p_done) else $error("done without last result");
  property p_ignore;
    @(posedge mclk_in) disable iff (rst_in)
    r.state != dxsc_pkg::DXSC_MEAS |=> !result_valid_out;
  endproperty
  a_ignore: assert property (p_ignore) else $error("result outside measurement");
  property p_res_hold;
    @(posedge mclk_in) disable iff (rst_in)
    !(r.state == dxsc_pkg::DXSC_MEAS && meas_done_in)
    |=> $stable(result_real_out) && $stable(result_imag_out);
  endproperty
  a_res_hold: assert property (p_res_hold) else $error("result words changed");
  property p_pll_src;
    @(posedge mclk_in) disable iff (rst_in)
    r.src == dxsc_pkg::SRC_PLL && !(r.pll_s2 && !r.pll_s3) |-> !ce;
  endproperty
  a_pll_src: assert property (p_pll_src) else $error("ce without pll tick");
  property p_div_hold;
    @(posedge mclk_in) disable iff (rst_in)
    !src_tick |=> $stable(r.div);
  endproperty
  a_div_hold: assert property (p_div_hold) else $error("divider moved untimed");
  property p_point;
    @(posedge mclk_in) disable iff (rst_in)
    r.state == dxsc_pkg::DXSC_MEAS && meas_done_in && !stop_in && r.point < r.pts
    |=> point_out == $past(point_out) + PTS_W'(1);
  endproperty
  a_point: assert property (p_point) else $error("point did not advance");
  property p_range_hold;
    @(posedge mclk_in) disable iff (rst_in)
    r.state != dxsc_pkg::DXSC_IDLE |=> $stable(range_out);
  endproperty
  a_range_hold: assert property (p_range_hold) else $error("range moved in run");
  c_fixed: cover property (@(posedge mclk_in) r.state == dxsc_pkg::DXSC_FIXED);
  c_done: cover property (@(posedge mclk_in) sweep_done_out);
  c_pll: cover property (@(posedge mclk_in) pll_mult_out && ce);
  c_refuse: cover property (@(posedge mclk_in) start_in && busy_out);
  c_rc: cover property (@(posedge mclk_in) r.src == dxsc_pkg::SRC_RC && ce);
endmodule

// file: dxsc_pkg.sv
// Package for the excitation sweep control: widths, reset values, counts.
// Assumes a single 40 MHz clock with synchronous active-high reset.
package dxsc_pkg;
  localparam int FREQ_W = 27;
  localparam int ADDR_W = 12;
  localparam int DAC_W = 10;
  localparam int PTS_W = 9;
  localparam int CLK_DIV = 4;
  localparam logic [1:0] DIV_LAST = 2'(CLK_DIV - 1);
  localparam int PLL_GAIN = 520;
  localparam int PLL_REF_HZ = 32000;
  localparam int MAX_OUT_HZ = 50000;
  localparam int MCLK_HZ = 40000000;
  // Phase step for 50 kHz at the divided rate: f*2^27/(mclk/4)
  localparam logic [FREQ_W-1:0] MAX_STEP =
    FREQ_W'((64'(MAX_OUT_HZ) << FREQ_W) / 64'(MCLK_HZ / CLK_DIV));
  localparam logic [1:0] SRC_EXT = 2'h0;
  localparam logic [1:0] SRC_RC = 2'h1;
  localparam logic [1:0] SRC_PLL = 2'h2;
  localparam logic [1:0] RANGE_2V = 2'h0;
  localparam logic [1:0] RANGE_1V = 2'h1;
  localparam logic [1:0] RANGE_0V5 = 2'h2;
  localparam logic [1:0] RANGE_0V2 = 2'h3;
  localparam int SETTLE_CYC = 16;
  localparam logic [15:0] RESULT_RST = 16'h0000;
  typedef enum logic [3:0] {
    DXSC_IDLE = 4'b0001,
    DXSC_SWEEP = 4'b0010,
    DXSC_MEAS = 4'b0100,
    DXSC_FIXED = 4'b1000
  } dxsc_state_t;
endpackage

// file: dxsc_nco.sv
// Oscillator: 27-bit phase accumulator, truncation and sine table.
// Assumes step_in is already clamped and ce_in is the divided DDS rate.
`timescale 1ns/1ps
module dxsc_nco #(
  parameter int FREQ_W = dxsc_pkg::FREQ_W,
  parameter int ADDR_W = dxsc_pkg::ADDR_W,
  parameter int DAC_W = dxsc_pkg::DAC_W
) (
  input wire logic mclk_in,
  input wire logic rst_in,
  input wire logic ce_in,
  input wire logic run_in,
  input wire logic [FREQ_W-1:0] step_in,
  output logic [DAC_W-1:0] sine_out
);
  typedef struct packed {
    logic [FREQ_W-1:0] phase;
    logic [DAC_W-1:0] sine;
  } dxsc_nco_t;
  dxsc_nco_t r;
  dxsc_nco_t next_r;
  logic [ADDR_W-1:0] addr;

  // Quarter-symmetric table from a parabola approximation
  function automatic logic [DAC_W-1:0] dxsc_sine(input logic [ADDR_W-1:0] a);
    logic [ADDR_W-3:0] q;
    logic [2*(ADDR_W-2)-1:0] sq;
    logic [DAC_W-2:0] mag;
    q = a[ADDR_W-2] ? ~a[ADDR_W-3:0] : a[ADDR_W-3:0];
    sq = (2*(ADDR_W-2))'(q) * (2*(ADDR_W-2))'(q);
    mag = (DAC_W-1)'(({q, 1'b0} - sq[2*(ADDR_W-2)-1:ADDR_W-2]) >> (ADDR_W - DAC_W));
    dxsc_sine = a[ADDR_W-1] ? DAC_W'({1'b0, ~mag}) : DAC_W'({1'b1, mag});
  endfunction

  assign addr = r.phase[FREQ_W-1 -: ADDR_W];
  assign sine_out = r.sine;

  always_comb begin
    next_r = r;
    if (ce_in && run_in) begin
      next_r.phase = r.phase + step_in;
      next_r.sine = dxsc_sine(addr);
    end
  end

  always_ff @(posedge mclk_in) begin
    if (rst_in) begin
      r <= '0;
    end else begin
      r <= next_r;
    end
  end

  property p_phase_step;
    @(posedge mclk_in) disable iff (rst_in)
    ce_in && run_in |=> r.phase == $past(r.phase) + $past(step_in);
  endproperty
  a_phase_step: assert property (p_phase_step) else $error("phase step wrong");
  property p_hold;
    @(posedge mclk_in) disable iff (rst_in)
    !ce_in |=> $stable(r.phase);
  endproperty
  a_hold: assert property (p_hold) else $error("phase moved without enable");
endmodule

// file: dxsc_meas_model.sv
// Measurement engine model: answers each request with one result pair.
// Assumes one-cycle request pulses; slow_in picks a long answer delay.
`timescale 1ns/1ps
module dxsc_meas_model (
  input wire logic mclk_in,
  input wire logic rst_in,
  input wire logic meas_req_in,
  input wire logic slow_in,
  output logic meas_done_out,
  output logic [15:0] real_out,
  output logic [15:0] imag_out
);
  logic [15:0] k;
  int wait_n;
  always_ff @(posedge mclk_in) begin
    if (rst_in) begin
      k <= 16'h0000;
      wait_n <= -1;
      meas_done_out <= 1'b0;
      real_out <= 16'h0000;
      imag_out <= 16'hFFFF;
    end else begin
      meas_done_out <= 1'b0;
      // Data lines toggle outside the result cycle
      real_out <= ~real_out;
      imag_out <= ~imag_out;
      if (meas_req_in) begin
        wait_n <= slow_in ? 20 : 1;
      end else if (wait_n > 0) begin
        wait_n <= wait_n - 1;
      end else if (wait_n == 0) begin
        meas_done_out <= 1'b1;
        real_out <= 16'hA000 + k;
        imag_out <= 16'h5000 + k;
        k <= k + 16'h0001;
        wait_n <= -1;
      end
    end
  end
endmodule

// file: dds_excitation_sweep_control_tb.sv
// Testbench: fixed and sweep runs, queued expectations, negedge monitor.
// Assumes the measurement model answers every request of the sweep.
`timescale 1ns/1ps
module dds_excitation_sweep_control_tb;
  localparam int SETTLE = 4;
  logic mclk_in = 1'b0, rst_in = 1'b1, rc_tick_in = 1'b0, pll_tick_in = 1'b0;
  logic [1:0] clk_src_in = 2'h0, range_in = 2'h0;
  logic sweep_mode_in = 1'b0, start_in = 1'b0, stop_in = 1'b0, slow = 1'b0;
  logic [26:0] start_freq_in = 27'h0, delta_freq_in = 27'h0;
  logic [8:0] num_points_in = 9'h0;
  logic meas_done_in;
  logic [15:0] meas_real_in, meas_imag_in, result_real_out, result_imag_out;
  logic [9:0] excitation_output;
  logic [1:0] range_out;
  logic [26:0] freq_out;
  logic [8:0] point_out;
  logic dds_ce_out, busy_out, meas_req_out, result_valid_out, sweep_done_out, pll_mult_out;
  int checks = 0, n_mismatch = 0, seed = 34, n_res = 0, tick_cnt = 0;
  logic [35:0] fq[$];
  logic [32:0] rq[$];
  logic [35:0] fexp;
  logic [32:0] rexp;
  dxsc_top #(.SETTLE(SETTLE)) dut (.mclk_in(mclk_in), .rst_in(rst_in),
    .clk_src_in(clk_src_in), .rc_tick_in(rc_tick_in), .pll_tick_in(pll_tick_in),
    .range_in(range_in), .sweep_mode_in(sweep_mode_in), .start_freq_in(start_freq_in),
    .delta_freq_in(delta_freq_in), .num_points_in(num_points_in), .start_in(start_in),
    .stop_in(stop_in), .meas_done_in(meas_done_in), .meas_real_in(meas_real_in),
    .meas_imag_in(meas_imag_in), .excitation_output(excitation_output),
    .range_out(range_out), .freq_out(freq_out), .point_out(point_out),
    .dds_ce_out(dds_ce_out), .busy_out(busy_out), .meas_req_out(meas_req_out),
    .result_valid_out(result_valid_out), .result_real_out(result_real_out),
    .result_imag_out(result_imag_out), .sweep_done_out(sweep_done_out),
    .pll_mult_out(pll_mult_out));
  dxsc_meas_model partner (.mclk_in(mclk_in), .rst_in(rst_in), .meas_req_in(meas_req_out),
    .slow_in(slow), .meas_done_out(meas_done_in), .real_out(meas_real_in),
    .imag_out(meas_imag_in));
  initial begin
    forever #12.5 mclk_in = ~mclk_in;
  end
  always @(posedge mclk_in) begin
    tick_cnt <= tick_cnt + 1;
    if (tick_cnt % 3 == 0) rc_tick_in <= ~rc_tick_in;
    if (tick_cnt % 5 == 0) pll_tick_in <= ~pll_tick_in;
  end
  task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
    checks++;
    if (exp !== got) begin
      n_mismatch++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic end_sim();
    $display("checks=%0d n_mismatch=%0d", checks, n_mismatch);
    if (n_mismatch == 0 && checks > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  always @(negedge mclk_in) begin
    if (meas_req_out === 1'b1) begin
      if (fq.size() == 0) check("spurious meas_req_out", 0, 1);
      else begin
        fexp = fq.pop_front();
        check("freq_out", 32'(fexp[26:0]), 32'(freq_out));
        check("point_out", 32'(fexp[35:27]), 32'(point_out));
      end
    end
    if (result_valid_out === 1'b1) begin
      if (rq.size() == 0) check("spurious result", 0, 1);
      else begin
        rexp = rq.pop_front();
        check("result", rexp[31:0], {result_real_out, result_imag_out});
        check("sweep_done_out", 32'(rexp[32]), 32'(sweep_done_out));
      end
    end
  end
  task automatic sweep(input logic [26:0] f0, input logic [26:0] df, input logic [8:0] np,
                       input logic s);
    int i;
    @(posedge mclk_in);
    start_freq_in <= f0;
    delta_freq_in <= df;
    num_points_in <= np;
    sweep_mode_in <= 1'b1;
    slow <= s;
    @(posedge mclk_in);
    start_in <= 1'b1;
    for (i = 0; i <= int'(np); i++) begin
      fq.push_back({9'(i), f0 + 27'(i) * df});
      rq.push_back({1'(i == int'(np)), 16'hA000 + 16'(n_res), 16'h5000 + 16'(n_res)});
      n_res++;
    end
    @(posedge mclk_in);
    start_in <= 1'b0;
    repeat (2) @(posedge mclk_in);
    start_in <= 1'b1;
    @(posedge mclk_in);
    start_in <= 1'b0;
    for (i = 0; i < 5000 && busy_out !== 1'b0; i++) @(negedge mclk_in);
    repeat (40) @(negedge mclk_in);
    check("queues drained", 0, 32'(rq.size() + fq.size()));
  endtask
  task automatic fixed_run(input logic [1:0] src, input logic [1:0] rng, input logic [26:0] f);
    int n;
    logic [9:0] first;
    @(posedge mclk_in);
    clk_src_in <= src;
    range_in <= rng;
    sweep_mode_in <= 1'b0;
    start_freq_in <= f;
    repeat (3) @(negedge mclk_in);
    check("range_out", 32'(rng), 32'(range_out));
    check("pll_mult_out", 32'(src == 2'h2), 32'(pll_mult_out));
    n = 0;
    repeat (400) begin
      @(negedge mclk_in);
      n += int'(dds_ce_out === 1'b1);
    end
    if (src == 2'h0 || src == 2'h3) check("dds_ce count", 100, 32'(n));
    else check("dds_ce slow", 1, 32'(n > 5 && n < 30));
    check("idle busy", 0, 32'(busy_out));
    @(posedge mclk_in);
    start_in <= 1'b1;
    @(posedge mclk_in);
    start_in <= 1'b0;
    @(negedge mclk_in);
    check("busy_out", 1, 32'(busy_out));
    check("freq_out", 32'(f > dxsc_pkg::MAX_STEP ? dxsc_pkg::MAX_STEP : f), 32'(freq_out));
    first = excitation_output;
    n = 0;
    repeat (400) begin
      @(negedge mclk_in);
      n += int'(excitation_output !== first);
    end
    check("excitation moves", 1, 32'(n > 0));
    @(posedge mclk_in);
    stop_in <= 1'b1;
    @(posedge mclk_in);
    stop_in <= 1'b0;
    @(negedge mclk_in);
    check("stopped", 0, 32'(busy_out));
  endtask
  initial begin
    #(30000 * 25);
    n_mismatch++;
    end_sim();
  end
  initial begin
    repeat (16) @(posedge mclk_in);
    rst_in <= 1'b0;
    @(negedge mclk_in);
    check("reset range", 32'(dxsc_pkg::RANGE_2V), 32'(range_out));
    check("reset busy", 0, 32'(busy_out));
    check("reset result", 0, {result_real_out, result_imag_out});
    fixed_run(dxsc_pkg::SRC_EXT, dxsc_pkg::RANGE_2V, 27'h7FFFFFF);
    fixed_run(dxsc_pkg::SRC_RC, dxsc_pkg::RANGE_1V, 27'h7FFFFFF);
    fixed_run(dxsc_pkg::SRC_PLL, dxsc_pkg::RANGE_0V5,
              27'(32'($random(seed)) % 32'(dxsc_pkg::MAX_STEP)) + 27'h80000);
    fixed_run(2'h3, dxsc_pkg::RANGE_0V2, dxsc_pkg::MAX_STEP);
    sweep(27'(32'($random(seed)) % 32'h40000), 27'(32'($random(seed)) % 32'h10000),
          9'h003, 1'b0);
    sweep(27'(32'($random(seed)) % 32'h40000), 27'(32'($random(seed)) % 32'h10000),
          9'h002, 1'b1);
    end_sim();
  end
endmodule
